// File: transfer_branch_exec.sv
// Transfer and branch instruction execution unit with an APB register port
//
// What this block does
// RULE_01: Immediate move with index enabled writes location redirected by index value.
// RULE_02: Table read fetches program word at address register into data buffer.
// RULE_03: Table word lands as four nibbles, most significant in highest buffer nibble.
// RULE_04: Table read occupies one return stack level while it runs.
// RULE_05: Push decrements stack pointer, then stores address register at new entry.
// RULE_06: Pop loads address register from entry at pointer, then increments pointer.
// RULE_07: Peek copies the addressed register file nibble into the window register.
// RULE_08: Poke writes the window register nibble into the addressed register file.
// RULE_09: Register file 40H-7FH aliases current bank data memory, 74H-7FH system.
// RULE_10: Program status word sits at 7FH so peek of 7FH returns it.
// RULE_11: Peripheral get copies the addressed peripheral register into the buffer.
// RULE_12: Peripheral put copies the data buffer into the addressed peripheral.
// RULE_13: Data buffer nibbles always live at bank zero locations 0CH-0FH.
// RULE_14: Get from an 8-bit peripheral fills only the low 8 buffer bits.
// RULE_15: Put to an 8-bit peripheral transfers only the two low nibbles.
// RULE_16: Direct branch loads program counter from the instruction's address field.
// RULE_17: Indirect branch loads program counter from the address register.
// RULE_18: Indexed address is the bitwise OR of index value and operand address.
// RULE_19: Upper six address register bits read zero; ten bits are usable.
// RULE_20: Each instruction completes in one cycle before the next executes.
`timescale 1ns/1ps
`include "tbx_defines.svh"
module transfer_branch_exec #(
  parameter int BANK_W = 1
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory read port
  output logic [9:0]       pmem_addr,
  input  wire logic [15:0] pmem_data,
  // Peripheral access
  output logic             periph_re,
  output logic [6:0]       periph_addr,
  input  wire logic [15:0] periph_rdata,
  input  wire logic        periph_wide,
  output logic             periph_we,
  output logic [6:0]       periph_waddr,
  output logic [15:0]      periph_wdata,
  // Status
  output logic [3:0]       program_status_word
);
  localparam int DM_W  = BANK_W + 7;
  localparam int DM_N  = 1 << DM_W;
  localparam int RS_N  = 8;

  tbx_pkg::state_t s_reg;
  tbx_pkg::state_t s_next;
  tbx_pkg::op_t    op;

  // Memories sit outside the state struct; arrays do not pack
  logic [3:0]  dmem [DM_N];
  logic [3:0]  rfile [64];
  logic [9:0]  rstack [RS_N];

  logic            dm_we;
  logic [DM_W-1:0] dm_wa;
  logic [3:0]      dm_wd;
  logic            buf_we;
  logic [3:0]      buf_mask;
  logic [15:0]     buf_wd;
  logic            regf_we;
  logic [5:0]      regf_wa;
  logic [3:0]      regf_wd;
  logic            rs_we;
  logic [2:0]      rs_wa;
  logic [9:0]      rs_wd;

  logic            wr_acc;
  logic            rd_setup;
  logic            exec;
  logic [15:0]     ins;
  logic [6:0]      rfa;
  logic [10:0]     eff_addr;
  logic [DM_W-1:0] regf_dm_idx;
  logic [3:0]      regf_rdata;
  logic [15:0]     buf_cur;
  logic            mapped;

  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign exec     = wr_acc & (paddr == `OFF_INSTR);
  assign ins      = pwdata[15:0];
  assign rfa      = {ins[10:8], ins[3:0]};

  // Buffer is pinned to bank zero whatever the bank register says [RULE_13]
  assign buf_cur = {dmem[DM_W'(`BUF_BASE) + DM_W'(3)], dmem[DM_W'(`BUF_BASE) + DM_W'(2)],
                    dmem[DM_W'(`BUF_BASE) + DM_W'(1)], dmem[DM_W'(`BUF_BASE)]};

  // Index OR, never add: carries would cross into the bank field [RULE_18]
  always_comb begin
    eff_addr = {s_reg.bank, ins[10:4]};
    if (s_reg.index_enable_flag) begin
      eff_addr = eff_addr | s_reg.index_value; // [RULE_01] [RULE_18]
    end
  end

  // System register part is shared, so it always resolves to bank zero [RULE_09]
  always_comb begin
    if (rfa >= `REGF_SYS_BASE) begin
      regf_dm_idx = DM_W'(rfa);
    end else begin
      regf_dm_idx = DM_W'({s_reg.bank, rfa});
    end
    if (rfa < `REGF_DM_BASE) begin
      regf_rdata = rfile[rfa[5:0]];
    end else begin
      regf_rdata = dmem[regf_dm_idx]; // [RULE_09] [RULE_10]
    end
  end

  always_comb begin
    op = tbx_pkg::OP_NONE;
    if (ins[15:11] == `OP_MOVI) begin
      op = tbx_pkg::OP_MOVI;
    end else if (ins[15:11] == `OP_JUMP) begin
      op = tbx_pkg::OP_JUMP;
    end else if (ins[15:11] == `OP_GROUP) begin
      unique case (ins[7:4])
        `FN_TABLE: op = tbx_pkg::OP_TABLE;
        `FN_PUSH: op = tbx_pkg::OP_PUSH;
        `FN_POP:  op = tbx_pkg::OP_POP;
        `FN_BRAR: op = tbx_pkg::OP_BRAR;
        `FN_PEEK: op = tbx_pkg::OP_PEEK;
        `FN_POKE: op = tbx_pkg::OP_POKE;
        `FN_GET:  op = tbx_pkg::OP_GET;
        `FN_PUT:  op = tbx_pkg::OP_PUT;
        default:  op = tbx_pkg::OP_NONE;
      endcase
    end
  end

  // Peripheral select is combinational so a get finishes in its own cycle
  assign periph_addr = rfa;
  assign periph_re   = exec & (op == tbx_pkg::OP_GET);
  assign pmem_addr   = s_reg.address_register;

  always_comb begin
    unique case (paddr)
      `OFF_INSTR, `OFF_PROG_CNT, `OFF_ADDR_REG, `OFF_STK_PTR, `OFF_BUF, `OFF_WR,
      `OFF_INDEX, `OFF_CTRL, `OFF_DADDR, `OFF_DDATA, `OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    s_next        = s_reg;
    s_next.per_we = 1'b0;
    dm_we    = 1'b0;
    dm_wa    = '0;
    dm_wd    = 4'h0;
    buf_we   = 1'b0;
    buf_mask = 4'h0;
    buf_wd   = 16'h0000;
    regf_we  = 1'b0;
    regf_wa  = 6'h00;
    regf_wd  = 4'h0;
    rs_we    = 1'b0;
    rs_wa    = 3'h0;
    rs_wd    = 10'h000;
    // Read data is captured in setup so it stands through the access phase
    if (rd_setup) begin
      unique case (paddr)
        `OFF_INSTR: s_next.prdata = {16'h0000, s_reg.last_instr};
        `OFF_PROG_CNT: s_next.prdata = {22'h000000, s_reg.program_counter};
        `OFF_ADDR_REG: s_next.prdata = {22'h000000, s_reg.address_register}; // [RULE_19]
        `OFF_STK_PTR:  s_next.prdata = {29'h00000000, s_reg.stack_pointer};
        `OFF_BUF:      s_next.prdata = {16'h0000, buf_cur};
        `OFF_WR:       s_next.prdata = {28'h0000000, s_reg.window_reg};
        `OFF_INDEX:    s_next.prdata = {21'h000000, s_reg.index_value};
        `OFF_CTRL:  s_next.prdata = {24'h000000, s_reg.bank, 3'h0, s_reg.index_enable_flag};
        `OFF_DADDR: s_next.prdata = {21'h000000, s_reg.dm_addr};
        `OFF_DDATA: s_next.prdata = {28'h0000000, dmem[s_reg.dm_addr[DM_W-1:0]]};
        `OFF_STATUS: s_next.prdata = {28'h0000000, dmem[DM_W'(`STATUS_ADDR)]};
        default:    s_next.prdata = 32'h00000000;
      endcase
    end
    if (wr_acc) begin
      unique case (paddr)
        `OFF_PROG_CNT: s_next.program_counter = pwdata[9:0];
        `OFF_ADDR_REG: s_next.address_register = pwdata[9:0]; // [RULE_19]
        `OFF_STK_PTR:  s_next.stack_pointer = pwdata[2:0];
        `OFF_WR:       s_next.window_reg = pwdata[3:0];
        `OFF_INDEX:    s_next.index_value = pwdata[10:0];
        `OFF_DADDR: s_next.dm_addr = pwdata[10:0];
        `OFF_CTRL: begin
          s_next.index_enable_flag = pwdata[`CTRL_IDX_EN];
          s_next.bank = pwdata[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
        end
        `OFF_BUF: begin
          buf_we   = 1'b1;
          buf_mask = 4'hf;
          buf_wd   = pwdata[15:0];
        end
        `OFF_DDATA: begin
          dm_we = 1'b1;
          dm_wa = s_reg.dm_addr[DM_W-1:0];
          dm_wd = pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // Every instruction but put settles its destination at the edge it is written; put reaches the peripheral one edge later [RULE_20]
    if (exec) begin
      s_next.last_instr = ins;
      unique case (op)
        tbx_pkg::OP_MOVI: begin
          dm_we = 1'b1;
          dm_wa = eff_addr[DM_W-1:0]; // [RULE_01]
          dm_wd = ins[3:0];
        end
        tbx_pkg::OP_TABLE: begin
          // Return address parks one level below; pointer nets back unchanged
          rs_we    = 1'b1; // [RULE_04]
          rs_wa    = s_reg.stack_pointer - 3'h1;
          rs_wd    = s_reg.program_counter; // [RULE_04]
          buf_we   = 1'b1;
          buf_mask = 4'hf;
          buf_wd   = pmem_data; // [RULE_02] [RULE_03]
        end
        tbx_pkg::OP_PUSH: begin
          s_next.stack_pointer = s_reg.stack_pointer - 3'h1; // [RULE_05]
          rs_we = 1'b1;
          rs_wa = s_reg.stack_pointer - 3'h1; // [RULE_05]
          rs_wd = s_reg.address_register;
        end
        tbx_pkg::OP_POP: begin
          s_next.address_register = rstack[s_reg.stack_pointer]; // [RULE_06]
          s_next.stack_pointer = s_reg.stack_pointer + 3'h1; // [RULE_06]
        end
        tbx_pkg::OP_PEEK: begin
          s_next.window_reg = regf_rdata; // [RULE_07] [RULE_10]
        end
        tbx_pkg::OP_POKE: begin
          if (rfa < `REGF_DM_BASE) begin
            regf_we = 1'b1; // [RULE_08]
            regf_wa = rfa[5:0];
            regf_wd = s_reg.window_reg;
          end else begin
            dm_we = 1'b1; // [RULE_09]
            dm_wa = regf_dm_idx;
            dm_wd = s_reg.window_reg;
          end
        end
        tbx_pkg::OP_GET: begin
          buf_we   = 1'b1; // [RULE_11]
          buf_mask = periph_wide ? 4'hf : 4'h3; // [RULE_14]
          buf_wd   = periph_rdata;
        end
        tbx_pkg::OP_PUT: begin
          s_next.per_we    = 1'b1; // [RULE_12]
          s_next.per_waddr = rfa;
          s_next.per_wdata = periph_wide ? buf_cur : {8'h00, buf_cur[7:0]}; // [RULE_15]
        end
        tbx_pkg::OP_JUMP: begin
          s_next.program_counter = ins[9:0]; // [RULE_16]
        end
        tbx_pkg::OP_BRAR: begin
          s_next.program_counter = s_reg.address_register; // [RULE_17]
        end
        tbx_pkg::OP_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{
        program_counter:   `RST_PROG_CNT,
        address_register:  `RST_ADDR_REG,
        stack_pointer:     `RST_STK_PTR,
        window_reg:        `RST_WR,
        index_value:       `RST_INDEX,
        index_enable_flag: 1'b0,
        bank:              `RST_BANK,
        last_instr:        `RST_INSTR,
        dm_addr:           11'h000,
        prdata:            32'h00000000,
        per_we:            1'b0,
        per_waddr:         7'h00,
        per_wdata:         16'h0000
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // Memory contents are left unreset; software initialises what it uses
  always_ff @(posedge pclk) begin
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
    if (buf_we) begin
      for (int i = 0; i < 4; i++) begin
        if (buf_mask[i]) begin
          dmem[DM_W'(`BUF_BASE) + DM_W'(i)] <= buf_wd[4*i +: 4]; // [RULE_03] [RULE_13]
        end
      end
    end
    if (regf_we) begin
      rfile[regf_wa] <= regf_wd;
    end
    if (rs_we) begin
      rstack[rs_wa] <= rs_wd;
    end
  end

  assign prdata              = s_reg.prdata;
  assign periph_we           = s_reg.per_we;
  assign periph_waddr        = s_reg.per_waddr;
  assign periph_wdata        = s_reg.per_wdata;
  assign program_status_word = dmem[DM_W'(`STATUS_ADDR)]; // [RULE_10]

endmodule

// File: tbx_defines.svh
// Offsets, encodings, field positions and reset values for the transfer/branch unit
`ifndef TBX_DEFINES_SVH
`define TBX_DEFINES_SVH
`define OFF_INSTR     8'h00
`define OFF_PROG_CNT  8'h04
`define OFF_ADDR_REG  8'h08
`define OFF_STK_PTR   8'h0c
`define OFF_BUF       8'h10
`define OFF_WR        8'h14
`define OFF_INDEX     8'h18
`define OFF_CTRL      8'h1c
`define OFF_DADDR     8'h20
`define OFF_DDATA     8'h24
`define OFF_STATUS    8'h28
`define CTRL_IDX_EN   0
`define CTRL_BANK_LSB 4
`define CTRL_BANK_MSB 7
`define OP_GROUP      5'h07
`define OP_MOVI       5'h1d
`define OP_JUMP       5'h0c
`define FN_TABLE      4'h1
`define FN_PUSH       4'hd
`define FN_POP        4'hc
`define FN_BRAR       4'h4
`define FN_PEEK       4'h3
`define FN_POKE       4'h2
`define FN_GET        4'hb
`define FN_PUT        4'ha
`define REGF_DM_BASE  7'h40
`define REGF_SYS_BASE 7'h74
`define STATUS_ADDR   7'h7f
`define BUF_BASE      7'h0c
`define RST_PROG_CNT  10'h000
`define RST_ADDR_REG  10'h000
`define RST_STK_PTR   3'h0
`define RST_WR        4'h0
`define RST_INDEX     11'h000
`define RST_BANK      4'h0
`define RST_INSTR     16'h0000
`endif

// File: tbx_pkg.sv
// Types shared by the transfer/branch unit
package tbx_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_MOVI, OP_TABLE, OP_PUSH, OP_POP, OP_PEEK,
    OP_POKE, OP_GET, OP_PUT, OP_JUMP, OP_BRAR
  } op_t;
  typedef struct packed {
    logic [9:0]  program_counter;
    logic [9:0]  address_register;
    logic [2:0]  stack_pointer;
    logic [3:0]  window_reg;
    logic [10:0] index_value;
    logic        index_enable_flag;
    logic [3:0]  bank;
    logic [15:0] last_instr;
    logic [10:0] dm_addr;
    logic [31:0] prdata;
    logic        per_we;
    logic [6:0]  per_waddr;
    logic [15:0] per_wdata;
  } state_t;
endpackage

// File: transfer_branch_exec_properties.sv
// Port-level concurrent checks for the transfer and branch unit
`timescale 1ns/1ps
`include "tbx_defines.svh"
module transfer_branch_exec_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Far side
  input wire logic [9:0]  pmem_addr,
  input wire logic [15:0] pmem_data,
  input wire logic        periph_re,
  input wire logic [6:0]  periph_addr,
  input wire logic [15:0] periph_rdata,
  input wire logic        periph_wide,
  input wire logic        periph_we,
  input wire logic [6:0]  periph_waddr,
  input wire logic [15:0] periph_wdata,
  input wire logic [3:0]  program_status_word
);
  logic       acc_w;
  logic       instr_w;
  logic       get_w;
  logic       put_w;
  logic       addr_src;
  logic [6:0] pa;
  logic [9:0] ard;
  assign acc_w   = psel && penable && pwrite;
  assign instr_w = acc_w && paddr == `OFF_INSTR && pwdata[15:11] == `OP_GROUP;
  assign get_w   = instr_w && pwdata[7:4] == `FN_GET;
  assign put_w   = instr_w && pwdata[7:4] == `FN_PUT;
  assign addr_src = acc_w && (paddr == `OFF_ADDR_REG || paddr == `OFF_INSTR);
  assign pa      = {pwdata[10:8], pwdata[3:0]};
  assign ard     = pwdata[9:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_const: assert property (pready)
    else $error("pready low");
  chk_get_strobe: assert property (get_w |-> periph_re && periph_addr == pa)
    else $error("get strobe or address wrong");
  chk_put_pulse: assert property (put_w |=> periph_we && periph_waddr == $past(pa))
    else $error("put pulse missing");
  chk_put_narrow: assert property (put_w && !periph_wide |=> periph_wdata[15:8] == 8'h00)
    else $error("narrow put carried upper nibbles");
  chk_we_single: assert property (periph_we |=> !periph_we)
    else $error("write pulse too long");
  chk_idle_no_we: assert property (!psel |=> !periph_we)
    else $error("write without put");
  chk_addr_to_pmem: assert property (acc_w && paddr == `OFF_ADDR_REG |=> pmem_addr == $past(ard))
    else $error("table address not from address register");
  chk_addr_upper: assert property (psel && penable && !pwrite && paddr == `OFF_ADDR_REG
    |-> prdata[31:10] == 22'h0)
    else $error("address register upper bits set");
  chk_pmem_cause: assert property ($changed(pmem_addr) |-> $past(addr_src))
    else $error("table address changed without cause");
endmodule
bind transfer_branch_exec transfer_branch_exec_properties transfer_branch_exec_properties_i (.*);

// File: far_side_model.sv
// Program memory and peripheral registers facing the transfer unit
`timescale 1ns/1ps
module far_side_model (
  // Clock
  input  wire logic        pclk,
  // Program memory
  input  wire logic [9:0]  pmem_addr,
  output logic [15:0]      pmem_data,
  // Peripherals
  input  wire logic        periph_re,
  input  wire logic [6:0]  periph_addr,
  output logic [15:0]      periph_rdata,
  output logic             periph_wide,
  input  wire logic        periph_we,
  input  wire logic [6:0]  periph_waddr,
  input  wire logic [15:0] periph_wdata
);
  logic [15:0] regs [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 16'h5a00 | 16'(i);
    end
  end
  // Table word derived from its address
  assign pmem_data = {pmem_addr[5:0], pmem_addr} ^ 16'ha5c3;
  // Upper half of the map is 16 bits wide, lower half 8
  assign periph_wide = periph_addr[6];
  // Unselected bus inverts, so a stale sample never passes
  assign periph_rdata = periph_re ? regs[periph_addr] : ~regs[periph_addr];
  always @(posedge pclk) begin
    if (periph_we) begin
      regs[periph_waddr] <= periph_wdata;
    end
  end
endmodule

// File: transfer_branch_exec_test.sv
// Self-checking bench for the transfer and branch unit
`timescale 1ns/1ps
`include "tbx_defines.svh"
module transfer_branch_exec_test;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, periph_re, periph_wide, periph_we;
  logic [9:0]  pmem_addr;
  logic [15:0] pmem_data, periph_rdata, periph_wdata;
  logic [6:0]  periph_addr, periph_waddr;
  logic [3:0]  program_status_word;
  logic [22:0] last_put;
  int          mismatches, total_checks, cycles;
  logic [10:0] ixv [2] = '{11'h032, 11'h013};
  logic [6:0]  mv [2] = '{7'h00, 7'h21};
  transfer_branch_exec transfer_branch_exec_i (.*);
  far_side_model far_side_model_i (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (periph_we === 1'b1) begin
      last_put <= {periph_waddr, periph_wdata};
    end
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Setup then access; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFF_PROG_CNT, 32'h0, "prog_cnt");
    rdc(`OFF_STK_PTR, 32'h0, "stk_ptr");
    rdc(8'h40, 32'h0, "unmapped");
    chk("unmapped_err", {31'h0, err}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      wr(`OFF_INDEX, {21'h0, ixv[i]});
      wr(`OFF_CTRL, 32'h1);
      wr(`OFF_INSTR, {16'h0, 5'h1d, mv[i], 4'h7 + 4'(i)});
      wr(`OFF_CTRL, 32'h0);
      wr(`OFF_DADDR, {21'h0, ixv[i] | {4'h0, mv[i]}});
      rdc(`OFF_DDATA, 32'h7 + 32'(i), "indexed_mov");
    end
    $display("index test done");
    wr(`OFF_PROG_CNT, 32'h155);
    wr(`OFF_STK_PTR, 32'h0);
    wr(`OFF_ADDR_REG, 32'h11);
    wr(`OFF_INSTR, 32'h3810);
    rdc(`OFF_BUF, 32'he1d2, "table_word");
    rdc(`OFF_STK_PTR, 32'h0, "table_stk");
    rdc(`OFF_PROG_CNT, 32'h155, "table_cnt");
    wr(`OFF_STK_PTR, 32'h7);
    wr(`OFF_INSTR, 32'h38c0);
    rdc(`OFF_ADDR_REG, 32'h155, "table_stack");
    $display("table test done");
    wr(`OFF_STK_PTR, 32'h0);
    wr(`OFF_ADDR_REG, 32'h12a);
    wr(`OFF_INSTR, 32'h38d0);
    wr(`OFF_ADDR_REG, 32'hc5);
    wr(`OFF_INSTR, 32'h38d0);
    rdc(`OFF_STK_PTR, 32'h6, "push_stk");
    wr(`OFF_ADDR_REG, 32'h0);
    wr(`OFF_INSTR, 32'h38c0);
    rdc(`OFF_ADDR_REG, 32'hc5, "pop_addr");
    rdc(`OFF_STK_PTR, 32'h7, "pop_stk");
    wr(`OFF_INSTR, 32'h38c0);
    rdc(`OFF_ADDR_REG, 32'h12a, "pop_addr2");
    wr(`OFF_ADDR_REG, 32'hffffffff);
    rdc(`OFF_ADDR_REG, 32'h3ff, "addr_width");
    $display("stack test done");
    wr(`OFF_INSTR, 32'h62c3);
    rdc(`OFF_PROG_CNT, 32'h2c3, "jump_direct");
    wr(`OFF_ADDR_REG, 32'h1f0);
    wr(`OFF_INSTR, 32'h3840);
    rdc(`OFF_PROG_CNT, 32'h1f0, "jump_indirect");
    $display("branch test done");
    wr(`OFF_WR, 32'ha);
    wr(`OFF_INSTR, 32'h3825);
    wr(`OFF_WR, 32'h0);
    wr(`OFF_INSTR, 32'h3835);
    rdc(`OFF_WR, 32'ha, "peek_poke");
    wr(`OFF_WR, 32'h6);
    wr(`OFF_INSTR, 32'h3d2f);
    wr(`OFF_DADDR, 32'h5f);
    rdc(`OFF_DDATA, 32'h6, "rf_alias");
    wr(`OFF_WR, 32'h9);
    wr(`OFF_INSTR, 32'h3f2f);
    rdc(`OFF_STATUS, 32'h9, "status_reg");
    chk("status_port", {28'h0, program_status_word}, 32'h9);
    wr(`OFF_WR, 32'h0);
    wr(`OFF_INSTR, 32'h3f3f);
    rdc(`OFF_WR, 32'h9, "status_peek");
    $display("register file test done");
    wr(`OFF_CTRL, 32'h10);
    wr(`OFF_BUF, 32'h4321);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_DADDR, 32'hc + 32'(i));
      rdc(`OFF_DDATA, 32'h1 + 32'(i), "buf_nibble");
    end
    wr(`OFF_INSTR, 32'h3cb5);
    rdc(`OFF_BUF, 32'h5a45, "get_wide");
    wr(`OFF_BUF, 32'hffff);
    wr(`OFF_INSTR, 32'h39b2);
    rdc(`OFF_BUF, 32'hff12, "get_narrow");
    wr(`OFF_BUF, 32'hbeef);
    wr(`OFF_INSTR, 32'h3ca5);
    rdc(`OFF_BUF, 32'hbeef, "put_keeps_buf");
    chk("put_wide", {9'h0, last_put}, {9'h0, 7'h45, 16'hbeef});
    wr(`OFF_INSTR, 32'h39a2);
    rdc(`OFF_BUF, 32'hbeef, "put_keeps_buf");
    chk("put_narrow", {9'h0, last_put}, {9'h0, 7'h12, 16'h00ef});
    $display("peripheral test done");
    report_and_stop();
  end
endmodule
